/* design/stepper_move_pkg.sv */
// Purpose: shared constants and types for the stepper move/position core
// Assumes: 20 MHz clk, synchronous active-high srst
// Notes:   speeds in steps/s, accel in steps/s/ms at the ports
package stepper_move_pkg;
   // widths
   localparam int POS_W  = 32;
   localparam int SPD_W  = 21;
   localparam int ACC_W  = 16;
   localparam int ACCS_W = 26;
   localparam int SPR_W  = 16;
   // ranges of host values
   localparam logic signed [POS_W-1:0] TGT_MAX   = 32'sh007FFFFF;
   localparam logic signed [POS_W-1:0] TGT_MIN   = -32'sh007FFFFF;
   localparam logic [SPD_W-1:0]        START_MIN = 21'h000001;
   localparam logic [SPD_W-1:0]        START_MAX = 21'h1E847F;
   localparam logic [9:0]              ACCEL_SCALE = 10'h3E8;
   // profile planning time in clocks
   localparam int PLAN_CYCLES = 4;
   localparam logic [2:0] PLAN_LAST = 3'(PLAN_CYCLES - 1);
   // reset values
   localparam logic [SPR_W-1:0] SPR_RST   = 16'h00C8;
   localparam logic [SPD_W-1:0] START_RST = 21'h000064;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PLAN = 2'b01,
      ST_RUN  = 2'b10
   } state_e;

   typedef enum logic [2:0] {
      KIND_REL                = 3'b000,
      KIND_ABS                = 3'b001,
      KIND_JOG_FWD            = 3'b010,
      KIND_REVERSE_MANUAL_RUN = 3'b011,
      KIND_HOME_FWD           = 3'b100,
      KIND_HOME_REV           = 3'b101
   } kind_e;
endpackage : stepper_move_pkg

/* design/stepper_move_position_core.sv */
// Purpose: motor position counter, move planning and command handling
// Assumes: step_tick, enc_inc, enc_dec, profile_done come from same clock
// Notes:   home_sense is a pin and is synchronised before use
//
// What this block does
// - plan the whole profile first, then start motion, report an error or finish a zero-length move at once
// - distances are in steps; steps per revolution comes from configuration
// - every speed value is taken as steps per second
// - accel and decel arrive per millisecond and are scaled up by 1000
// - motor position is a signed 32-bit count
// - preset command loads its value straight into the motor position while idle
// - find-home zeroes motor and encoder position when home is reached
// - clockwise steps count up, counter-clockwise steps count down
// - starting speed is configured and accepted only from 1 to 1999999
// - moves begin and end at the configured starting speed
// - operation works with no home ever defined
// - relative or absolute targets lie within +/-8388607; positive is CW
// - after an immediate stop, refuse absolute moves until homed or preset
`timescale 1ns/1ps
module stepper_move_position_core
   import stepper_move_pkg::*;
(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    srst,
   // configuration
   input  wire logic                    cfg_load,
   input  wire logic [SPR_W-1:0]        cfg_steps_per_rev,
   input  wire logic [SPD_W-1:0]        cfg_start_speed,
   output logic                         cfg_err,
   output logic [SPR_W-1:0]             steps_per_rev,
   output logic [SPD_W-1:0]             start_speed,
   // commands
   input  wire logic                    preset_req,
   input  wire logic signed [POS_W-1:0] preset_value,
   input  wire logic                    move_req,
   input  wire logic [2:0]              move_kind,
   input  wire logic signed [POS_W-1:0] move_target,
   input  wire logic [SPD_W-1:0]        move_speed,
   input  wire logic [ACC_W-1:0]        move_accel,
   input  wire logic [ACC_W-1:0]        move_decel,
   input  wire logic                    imm_stop,
   // motion feedback
   input  wire logic                    step_tick,
   input  wire logic                    profile_done,
   input  wire logic                    enc_inc,
   input  wire logic                    enc_dec,
   input  wire logic                    home_sense,
   // planned profile
   output logic                         move_start,
   output logic                         move_err,
   output logic                         move_done,
   output logic                         running,
   output logic                         plan_cw,
   output logic [POS_W-1:0]             plan_steps,
   output logic [SPD_W-1:0]             plan_speed,
   output logic [ACCS_W-1:0]            plan_accel,
   output logic [ACCS_W-1:0]            plan_decel,
   // positions
   output logic signed [POS_W-1:0]      motor_pos,
   output logic signed [POS_W-1:0]      enc_pos,
   output logic                         pos_valid
);

   typedef struct packed {
      state_e                    state;
      kind_e                     kind;
      logic [2:0]                plan_cnt;
      logic signed [POS_W-1:0]   tgt;
      logic [SPD_W-1:0]          spd;
      logic [ACC_W-1:0]          acc;
      logic [ACC_W-1:0]          dec;
      logic                      cw;
      logic [POS_W-1:0]          remaining;
      logic [SPD_W-1:0]          plan_spd;
      logic [ACCS_W-1:0]         plan_acc;
      logic [ACCS_W-1:0]         plan_dec;
      logic signed [POS_W-1:0]   pos;
      logic signed [POS_W-1:0]   enc;
      logic                      pos_valid;
      logic [SPR_W-1:0]          spr;
      logic [SPD_W-1:0]          start_spd;
      logic                      cfg_ok;
      logic                      cfg_err;
      logic                      start_pulse;
      logic                      err_pulse;
      logic                      done_pulse;
      logic                      running;
      logic                      home_meta;
      logic                      home_sync;
      logic                      home_prev;
   } core_s;

   core_s q_ff;
   core_s nxt_q;

   // steps/s/ms to steps/s^2
   function automatic logic [ACCS_W-1:0] scale_accel(
         input logic [ACC_W-1:0] a);
      scale_accel = ACCS_W'(a) * ACCS_W'(ACCEL_SCALE);
   endfunction : scale_accel

   // target inside the +/- window of relative and absolute moves
   function automatic logic tgt_ok(input logic signed [POS_W-1:0] t);
      tgt_ok = (t <= TGT_MAX) && (t >= TGT_MIN);
   endfunction : tgt_ok

   logic signed [POS_W:0] delta;
   logic                  home_edge;
   logic                  finite;
   logic                  bad;

   // distance and checks for the latched command
   always_comb begin
      delta = (q_ff.kind == KIND_ABS)
            ? ({q_ff.tgt[POS_W-1], q_ff.tgt} - {q_ff.pos[POS_W-1], q_ff.pos})
            : {q_ff.tgt[POS_W-1], q_ff.tgt};
      home_edge = q_ff.home_sync && !q_ff.home_prev;
      finite = (q_ff.kind == KIND_REL) || (q_ff.kind == KIND_ABS);
      bad = !q_ff.cfg_ok || (q_ff.spd == '0) || (q_ff.spd > START_MAX)
         || (q_ff.spd < q_ff.start_spd)
         || (q_ff.acc == '0) || (q_ff.dec == '0)
         || (finite && !tgt_ok(q_ff.tgt))
         || ((q_ff.kind == KIND_ABS) && !q_ff.pos_valid)
         || (q_ff.kind > KIND_HOME_REV);
   end

   // next-state of the whole core
   always_comb begin
      nxt_q = q_ff;
      nxt_q.start_pulse = 1'b0;
      nxt_q.err_pulse   = 1'b0;
      nxt_q.done_pulse  = 1'b0;
      // home sensor synchroniser
      nxt_q.home_meta = home_sense;
      nxt_q.home_sync = q_ff.home_meta;
      nxt_q.home_prev = q_ff.home_sync;
      // encoder counter
      if (enc_inc && !enc_dec) begin
         nxt_q.enc = q_ff.enc + 32'sh00000001;
      end else if (enc_dec && !enc_inc) begin
         nxt_q.enc = q_ff.enc - 32'sh00000001;
      end
      // configuration load
      if (cfg_load) begin
         if (cfg_start_speed >= START_MIN && cfg_start_speed <= START_MAX
             && cfg_steps_per_rev != '0) begin
            nxt_q.start_spd = cfg_start_speed;
            nxt_q.spr       = cfg_steps_per_rev;
            nxt_q.cfg_ok    = 1'b1;
            nxt_q.cfg_err   = 1'b0;
         end else begin
            nxt_q.cfg_err = 1'b1;
         end
      end
      case (q_ff.state)
         ST_IDLE: begin
            if (preset_req) begin
               nxt_q.pos       = preset_value;
               nxt_q.pos_valid = 1'b1;
            end else if (move_req) begin
               nxt_q.kind     = kind_e'(move_kind);
               nxt_q.tgt      = move_target;
               nxt_q.spd      = move_speed;
               nxt_q.acc      = move_accel;
               nxt_q.dec      = move_decel;
               nxt_q.plan_cnt = PLAN_LAST;
               nxt_q.state    = ST_PLAN;
            end
         end
         ST_PLAN: begin
            if (q_ff.plan_cnt != 3'h0) begin
               nxt_q.plan_cnt = q_ff.plan_cnt - 3'h1;
            end else if (bad) begin
               nxt_q.err_pulse = 1'b1;
               nxt_q.state     = ST_IDLE;
            end else if (finite && delta == '0) begin
               nxt_q.done_pulse = 1'b1;
               nxt_q.state      = ST_IDLE;
            end else begin
               nxt_q.cw = finite ? !delta[POS_W]
                  : (q_ff.kind == KIND_JOG_FWD)
                  || (q_ff.kind == KIND_HOME_FWD);
               nxt_q.remaining = delta[POS_W] ? POS_W'(-delta)
                                              : POS_W'(delta);
               nxt_q.plan_spd    = q_ff.spd;
               nxt_q.plan_acc    = scale_accel(q_ff.acc);
               nxt_q.plan_dec    = scale_accel(q_ff.dec);
               nxt_q.start_pulse = 1'b1;
               nxt_q.state       = ST_RUN;
            end
         end
         ST_RUN: begin
            if (imm_stop) begin
               nxt_q.pos_valid  = 1'b0;
               nxt_q.done_pulse = 1'b1;
               nxt_q.state      = ST_IDLE;
            end else begin
               if (step_tick) begin
                  nxt_q.pos = q_ff.cw ? q_ff.pos + 32'sh00000001
                                      : q_ff.pos - 32'sh00000001;
                  nxt_q.remaining = q_ff.remaining - 32'h00000001;
               end
               if ((q_ff.kind == KIND_HOME_FWD
                    || q_ff.kind == KIND_HOME_REV) && home_edge) begin
                  nxt_q.pos        = '0;
                  nxt_q.enc        = '0;
                  nxt_q.pos_valid  = 1'b1;
                  nxt_q.done_pulse = 1'b1;
                  nxt_q.state      = ST_IDLE;
               end else if (profile_done || (finite && step_tick
                            && q_ff.remaining == 32'h00000001)) begin
                  nxt_q.done_pulse = 1'b1;
                  nxt_q.state      = ST_IDLE;
               end
            end
         end
         default: nxt_q.state = ST_IDLE;
      endcase
      nxt_q.running = (nxt_q.state == ST_RUN);
   end

   // state register; position starts invalid, no home needed to run
   always_ff @(posedge clk) begin
      if (srst) begin
         q_ff           <= '0;
         q_ff.state     <= ST_IDLE;
         q_ff.spr       <= SPR_RST;
         q_ff.start_spd <= START_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // outputs straight from the state register
   assign cfg_err       = q_ff.cfg_err;
   assign steps_per_rev = q_ff.spr;
   assign start_speed   = q_ff.start_spd;
   assign move_start    = q_ff.start_pulse;
   assign move_err      = q_ff.err_pulse;
   assign move_done     = q_ff.done_pulse;
   assign running       = q_ff.running;
   assign plan_cw       = q_ff.cw;
   assign plan_steps    = q_ff.remaining;
   assign plan_speed    = q_ff.plan_spd;
   assign plan_accel    = q_ff.plan_acc;
   assign plan_decel    = q_ff.plan_dec;
   assign motor_pos     = q_ff.pos;
   assign enc_pos       = q_ff.enc;
   assign pos_valid     = q_ff.pos_valid;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_plan_first;
      q_ff.state == ST_IDLE && move_req && !preset_req
         |=> (q_ff.state == ST_PLAN)[*4];
   endproperty
   a_plan_first: assert property (p_plan_first)
      else $error("move left planning early");

   property p_start_after_plan;
      move_start |-> $past(q_ff.state) == ST_PLAN && running;
   endproperty
   a_start_after_plan: assert property (p_start_after_plan)
      else $error("move started without planning");

   property p_accel_scale;
      move_start |-> plan_accel == ACCS_W'(q_ff.acc) * ACCS_W'(ACCEL_SCALE)
                  && plan_decel == ACCS_W'(q_ff.dec) * ACCS_W'(ACCEL_SCALE);
   endproperty
   a_accel_scale: assert property (p_accel_scale)
      else $error("accel not scaled by 1000");

   property p_preset;
      q_ff.state == ST_IDLE && preset_req
         |=> motor_pos == $past(preset_value) && pos_valid;
   endproperty
   a_preset: assert property (p_preset)
      else $error("preset value not loaded");

   property p_home_zero;
      q_ff.state == ST_RUN && !imm_stop && home_edge
         && (q_ff.kind == KIND_HOME_FWD || q_ff.kind == KIND_HOME_REV)
         |=> motor_pos == '0 && enc_pos == '0 && move_done;
   endproperty
   a_home_zero: assert property (p_home_zero)
      else $error("home did not zero positions");

   property p_count_dir;
      q_ff.state == ST_RUN && !imm_stop && step_tick && !home_edge
         |=> motor_pos == ($past(plan_cw) ? $past(motor_pos) + 1
                                          : $past(motor_pos) - 1);
   endproperty
   a_count_dir: assert property (p_count_dir)
      else $error("position counted the wrong way");

   property p_cfg_range;
      cfg_load && (cfg_start_speed == '0 || cfg_start_speed > START_MAX)
         |=> cfg_err && start_speed == $past(start_speed);
   endproperty
   a_cfg_range: assert property (p_cfg_range)
      else $error("bad starting speed accepted");

   property p_imm_invalid;
      q_ff.state == ST_RUN && imm_stop |=> !pos_valid && !running;
   endproperty
   a_imm_invalid: assert property (p_imm_invalid)
      else $error("position still valid after immediate stop");

   property p_err_rest;
      move_err |-> !running ##1 !move_start;
   endproperty
   a_err_rest: assert property (p_err_rest)
      else $error("motion started on error");

   property p_cov_start;
      move_start;
   endproperty
   c_cov_start: cover property (p_cov_start);
   property p_cov_err;
      move_err;
   endproperty
   c_cov_err: cover property (p_cov_err);
   property p_cov_home;
      move_done && motor_pos == '0 && pos_valid;
   endproperty
   c_cov_home: cover property (p_cov_home);
   property p_cov_imm;
      running ##1 !pos_valid;
   endproperty
   c_cov_imm: cover property (p_cov_imm);

endmodule : stepper_move_position_core

/* tb/step_gen_model.sv */
// Purpose: behavioural step generator on the motion side of the core
// Assumes: same clock as the core; ticks only while running is high
// Notes:   gap sets tick spacing; 0 in stop or home count means never
`timescale 1ns/1ps
module step_gen_model (
   // clock and profile
   input  wire logic        clk,
   input  wire logic        running,
   input  wire logic        plan_cw,
   // behaviour controls
   input  wire logic [31:0] gap,
   input  wire logic [31:0] stop_after,
   input  wire logic [31:0] home_after,
   // feedback to the core
   output logic             step_tick,
   output logic             profile_done,
   output logic             enc_inc,
   output logic             enc_dec,
   output logic             home_sense
);
   int cnt = 0;
   int n   = 0;
   initial {step_tick, profile_done, enc_inc, enc_dec, home_sense} = '0;
   // one step per gap+1 cycles, encoder follows the direction
   always @(posedge clk) begin
      {step_tick, profile_done, enc_inc, enc_dec} <= '0;
      if (!running) begin
         cnt        <= 0;
         n          <= 0;
         home_sense <= 1'b0;
      end else if (cnt >= gap) begin
         cnt       <= 0;
         n         <= n + 1;
         step_tick <= 1'b1;
         enc_inc   <= plan_cw;
         enc_dec   <= !plan_cw;
         if (n + 1 == stop_after) profile_done <= 1'b1;
         if (n + 1 == home_after) home_sense <= 1'b1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : step_gen_model

/* tb/stepper_move_position_core_tb_top.sv */
// Purpose: self-checking bench for the move and position core
// Assumes: 20 MHz clk, inputs driven on the falling edge
// Notes:   driver queues expected result pulses, a monitor pops them
`timescale 1ns/1ps
module stepper_move_position_core_tb_top
   import stepper_move_pkg::*;
;
   localparam logic [2:0] ST = 3'h1;
   localparam logic [2:0] ER = 3'h2;
   localparam logic [2:0] DN = 3'h4;
   // stimulus, all set at time zero
   logic clk = 1'b0, srst = 1'b1, cfg_load = 1'b0, imm_stop = 1'b0;
   logic preset_req = 1'b0, move_req = 1'b0;
   logic [SPR_W-1:0]        cfg_steps_per_rev = '0;
   logic [SPD_W-1:0]        cfg_start_speed = '0;
   logic signed [POS_W-1:0] preset_value = '0, move_target = '0;
   logic [2:0]              move_kind = '0;
   logic [SPD_W-1:0]        move_speed = '0;
   logic [ACC_W-1:0]        move_accel = '0, move_decel = '0;
   logic [31:0]             gap = 32'h1, stop_after = '0, home_after = '0;
   // observed signals
   logic step_tick, profile_done, enc_inc, enc_dec, home_sense, cfg_err;
   logic move_start, move_err, move_done, running, plan_cw, pos_valid;
   logic [SPR_W-1:0]        steps_per_rev;
   logic [SPD_W-1:0]        start_speed, plan_speed;
   logic [POS_W-1:0]        plan_steps;
   logic [ACCS_W-1:0]       plan_accel, plan_decel;
   logic signed [POS_W-1:0] motor_pos, enc_pos;
   // bench state and refused-move table
   logic [2:0]              expq[$];
   int                      n_errors = 0, checked = 0, i, p, ra, rd;
   logic [SPR_W-1:0]        spr;
   logic [2:0] ek[9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h1};
   int et[9] = '{1, 1, 1, 1, 1, 32'h800000, -32'sh800000, 1, 5};
   int es[9] = '{0, 32'h1E8480, 32'h31, 32'h3E8, 32'h3E8, 32'h3E8,
                 32'h3E8, 32'h3E8, 32'h3E8};
   int ea[9] = '{9, 9, 9, 0, 9, 9, 9, 9, 9};
   int ed[9] = '{9, 9, 9, 9, 0, 9, 9, 9, 9};

   stepper_move_position_core i_stepper_move_position_core (
      .clk, .srst, .cfg_load, .cfg_steps_per_rev, .cfg_start_speed, .cfg_err,
      .steps_per_rev, .start_speed, .preset_req, .preset_value, .move_req,
      .move_kind, .move_target, .move_speed, .move_accel, .move_decel,
      .imm_stop, .step_tick, .profile_done, .enc_inc, .enc_dec, .home_sense,
      .move_start, .move_err, .move_done, .running, .plan_cw, .plan_steps,
      .plan_speed, .plan_accel, .plan_decel, .motor_pos, .enc_pos, .pos_valid
   );
   step_gen_model i_step_gen_model (
      .clk, .running, .plan_cw, .gap, .stop_after, .home_after, .step_tick,
      .profile_done, .enc_inc, .enc_dec, .home_sense
   );

   // clock
   always #25 clk = ~clk;

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   task automatic cfg(logic [SPR_W-1:0] s, logic [SPD_W-1:0] v, logic e);
      @(negedge clk);
      cfg_steps_per_rev = s;
      cfg_start_speed   = v;
      cfg_load          = 1'b1;
      @(negedge clk);
      cfg_load = 1'b0;
      chk("cfg_err", {31'h0, e}, {31'h0, cfg_err});
   endtask : cfg

   task automatic preset(int v);
      @(negedge clk);
      preset_value = v;
      preset_req   = 1'b1;
      @(negedge clk);
      preset_req = 1'b0;
      chk("motor_pos", v, motor_pos);
   endtask : preset

   // queue the answers, request, return when the answer is visible
   task automatic mv(logic [2:0] k, int t, int s, int a, int d,
                     logic [2:0] e0, logic [2:0] e1);
      expq.push_back(e0);
      if (e1 != 3'h0) expq.push_back(e1);
      @(negedge clk);
      move_kind   = k;
      move_target = t;
      move_speed  = SPD_W'(s);
      move_accel  = ACC_W'(a);
      move_decel  = ACC_W'(d);
      move_req    = 1'b1;
      @(negedge clk);
      move_req = 1'b0;
      repeat (3) @(negedge clk);
      chk("early running", 32'h0, {31'h0, running});
      @(negedge clk);
   endtask : mv

   task automatic idle();
      repeat (400) begin
         @(negedge clk);
         if (!running && expq.size() == 0) break;
      end
      chk("pending", 32'h0, expq.size());
      chk("stuck running", 32'h0, {31'h0, running});
   endtask : idle

   // result pulses against the oldest queued note
   always @(negedge clk) begin
      if (!srst && (move_start || move_err || move_done)) begin
         if (expq.size() == 0) chk("result", 32'h0, 32'h7);
         else chk("result", {29'h0, expq.pop_front()},
                  {29'h0, move_done, move_err, move_start});
      end
   end

   // watchdog, far beyond the expected run time
   initial begin
      #1000000;
      n_errors++;
      end_of_test();
   end

   // test sequence
   initial begin
      void'($urandom(95));
      spr = SPR_W'($urandom_range(32'hFFFF, 32'h1));
      ra  = $urandom_range(32'hFFFF, 32'h1);
      rd  = $urandom_range(32'hFFFF, 32'h1);
      p   = $urandom_range(32'h7A1200) - 32'h3D0900;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      chk("steps_per_rev", 32'hC8, steps_per_rev);
      chk("start_speed", 32'h64, start_speed);
      mv(3'h0, 1, 32'h3E8, 9, 9, ER, 3'h0);
      idle();
      $display("test reset ended");
      cfg(16'h190, 21'h0, 1'b1);
      cfg(16'h190, 21'h1E8480, 1'b1);
      cfg(16'h0, 21'h32, 1'b1);
      cfg(spr, 21'h1E847F, 1'b0);
      chk("start_speed", 32'h1E847F, start_speed);
      cfg(spr, 21'h32, 1'b0);
      chk("steps_per_rev", spr, steps_per_rev);
      $display("test config ended");
      for (i = 0; i < 9; i++) begin
         mv(ek[i], et[i], es[i], ea[i], ed[i], ER, 3'h0);
         idle();
      end
      chk("motor_pos", 32'h0, motor_pos);
      $display("test refusals ended");
      mv(3'h0, 3, 32'h3E8, ra, rd, ST, DN);
      chk("plan_steps", 32'h3, plan_steps);
      chk("plan_cw", 32'h1, plan_cw);
      chk("plan_speed", 32'h3E8, plan_speed);
      chk("plan_accel", ra * 32'h3E8, plan_accel);
      chk("plan_decel", rd * 32'h3E8, plan_decel);
      idle();
      chk("motor_pos", 32'h3, motor_pos);
      chk("enc_pos", 32'h3, enc_pos);
      mv(3'h0, 0, 32'h3E8, ra, rd, DN, 3'h0);
      idle();
      $display("test relative ended");
      gap = 32'h3;
      preset(32'h80000000);
      preset(32'h7FFFFFFF);
      preset(p);
      mv(3'h1, p - 2, 32'h3E8, ra, rd, ST, DN);
      chk("plan_cw", 32'h0, plan_cw);
      chk("plan_steps", 32'h2, plan_steps);
      idle();
      chk("motor_pos", p - 2, motor_pos);
      $display("test absolute ended");
      gap        = 32'h2;
      stop_after = 32'h4;
      mv(3'h3, 0, 32'h3E8, ra, rd, ST, DN);
      idle();
      chk("motor_pos", p - 6, motor_pos);
      chk("enc_pos", -3, enc_pos);
      stop_after = '0;
      mv(3'h2, 0, 32'h3E8, ra, rd, ST, DN);
      repeat (6) @(negedge clk);
      imm_stop = 1'b1;
      @(negedge clk);
      imm_stop = 1'b0;
      idle();
      chk("pos_valid", 32'h0, pos_valid);
      mv(3'h1, 5, 32'h3E8, ra, rd, ER, 3'h0);
      idle();
      mv(3'h0, 1, 32'h3E8, ra, rd, ST, DN);
      idle();
      $display("test jog ended");
      gap        = 32'h3; // keeps a step off the edge after home ends
      home_after = 32'h3;
      mv(3'h5, 0, 32'h3E8, ra, rd, ST, DN);
      idle();
      chk("motor_pos", 32'h0, motor_pos);
      chk("enc_pos", 32'h0, enc_pos);
      chk("pos_valid", 32'h1, pos_valid);
      home_after = '0;
      mv(3'h1, 2, 32'h3E8, ra, rd, ST, DN);
      idle();
      chk("motor_pos", 32'h2, motor_pos);
      $display("test home ended");
      end_of_test();
   end
endmodule : stepper_move_position_core_tb_top
